/* File: host_port_cfg.svh */
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define HP_CTRL_OFS        8'h00
`define HP_STAT_OFS        8'h04
`define HP_ACNT_OFS        8'h08
`define HP_CTRL_IRQ_BIT    0
`define HP_CTRL_DMA_BIT    1
`define HP_CTRL_LAT_LSB    4
`define HP_CTRL_LAT_MSB    7
`define HP_CTRL_RST        1'b0
`define HP_LAT_RST         4'h0
`define HP_STAT_RSHORT_BIT 6
`define HP_RESET_HOLD_US   300
`define HP_CLK_MHZ         200
`define HP_ALT_WR_BIT      22
`define HP_NARROW_AW       22
`endif

/* File: host_port_pkg.sv */
package host_port_pkg;
  typedef enum logic [2:0] {VAR_A, VAR_B, VAR_C, VAR_D, VAR_RSVD} variant_e;
  typedef enum logic [1:0] {ACC_IDLE, ACC_BUSY, ACC_DONE} acc_state_e;
endpackage

/* File: wait_line_if.sv */
`timescale 1ns/1ps
interface wait_line_if;
  logic ready_now;
  logic drive;
  logic ready_high;
  modport ctl (output ready_now, output drive, output ready_high);
  modport drv (input ready_now, input drive, input ready_high);
endinterface

/* File: sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end
endmodule

/* File: wait_line_drv.sv */
`timescale 1ns/1ps
module wait_line_drv (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  wait_line_if.drv   wl,
  output logic       wait_request_o,
  output logic       wait_request_oe_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_request_o    <= 1'b0;
      wait_request_oe_o <= 1'b0;
    end else begin
      wait_request_o    <= wl.ready_now ? wl.ready_high : ~wl.ready_high;
      wait_request_oe_o <= wl.drive;
    end
  end

  ready_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wl.ready_now && !wl.ready_high) |=> (wait_request_o == 1'b0))
    else $error("ready not shown as low level in variants B to D");
  drive_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wl.drive) |=> wait_request_oe_o ##0 $past(wl.drive))
    else $error("wait line enable did not follow drive request");
endmodule

/* File: host_bus_port.sv */
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_bus_port #(
  parameter int MEM_AW         = 8,
  parameter int RESET_HOLD_CYC = `HP_RESET_HOLD_US * `HP_CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  host_variant_sel_i,
  input  wire logic        ready_polarity_sel_i,
  input  wire logic        bus_start_present_sel_i,
  input  wire logic        hw_reset_n_i,
  input  wire logic        pll_reset_n_i,
  input  wire logic        bus_cycle_start_n_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic [3:0]  byte_write_strobe_n_i,
  input  wire logic [23:0] host_word_address_i,
  input  wire logic [31:0] host_bus_data_i,
  output logic      [31:0] host_bus_data_o,
  output logic             host_bus_data_oe_o,
  output logic             wait_request_o,
  output logic             wait_request_oe_o,
  output logic             dma_request_n_o,
  input  wire logic        dma_acknowledge_i,
  input  wire logic        dma_transfer_strobe_i,
  output logic             host_irq_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Address and data are sampled through the same two stages as the
  // strobes; the host holds them stable for the whole access.
  localparam int SW = 72;
  localparam logic [31:0] HOLD_CYC = 32'(RESET_HOLD_CYC);
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_syn;
  logic [2:0]    s_mode;
  logic          s_rdy_sel;
  logic          s_bs_sel;
  logic          s_hwr_n;
  logic          s_pll_n;
  logic          s_bs_n;
  logic          s_cs_n;
  logic          s_rd_n;
  logic [3:0]    s_we_n;
  logic          s_ack;
  logic          s_xstb;
  logic [23:0]   s_addr;
  logic [31:0]   s_data;

  assign pin_raw = {host_variant_sel_i, ready_polarity_sel_i, bus_start_present_sel_i,
                    hw_reset_n_i, pll_reset_n_i, bus_cycle_start_n_i, chip_sel_n_i,
                    read_strobe_n_i, byte_write_strobe_n_i, dma_acknowledge_i,
                    dma_transfer_strobe_i, host_word_address_i, host_bus_data_i};

  sync_2ff #(.W(SW)) u_sync (
    .clk_i (clk_i),
    .d_i   (pin_raw),
    .q_o   (pin_syn)
  );

  assign {s_mode, s_rdy_sel, s_bs_sel, s_hwr_n, s_pll_n, s_bs_n, s_cs_n, s_rd_n,
          s_we_n, s_ack, s_xstb, s_addr, s_data} = pin_syn;

  // ---------------------------------------------------------------
  // Reset and straps
  // ---------------------------------------------------------------
  logic                     port_rst;
  logic [4:0]               strap_reg;
  host_port_pkg::variant_e  variant;
  logic                     rdy_sel;
  logic                     bs_sel;

  assign port_rst = rst_i || !s_hwr_n;

  // Straps are taken only while the port is held in reset.
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      strap_reg <= {s_mode, s_rdy_sel, s_bs_sel};
    end
  end

  assign rdy_sel = strap_reg[1];
  assign bs_sel  = strap_reg[0];

  always_comb begin
    case (strap_reg[4:2])
      3'h0:    variant = host_port_pkg::VAR_A;
      3'h1:    variant = host_port_pkg::VAR_B;
      3'h2:    variant = host_port_pkg::VAR_C;
      3'h3:    variant = host_port_pkg::VAR_D;
      default: variant = host_port_pkg::VAR_RSVD;
    endcase
  end

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic        var_c;
  logic        var_cd;
  logic [23:0] addr_eff;
  logic        wr_req;
  logic        strobe_on;
  logic        go;
  logic        bs_seen_reg;
  host_port_pkg::acc_state_e state_reg;

  assign var_c    = (variant == host_port_pkg::VAR_C);
  assign var_cd   = var_c || (variant == host_port_pkg::VAR_D);
  assign addr_eff = var_cd ? {2'b00, s_addr[`HP_NARROW_AW-1:0]} : s_addr;
  // In variant C a write also needs the alternate memory-write strobe low.
  assign wr_req    = (s_we_n != 4'hf) && (!var_c || !s_addr[`HP_ALT_WR_BIT]);
  assign strobe_on = !s_cs_n && (!s_rd_n || wr_req);
  assign go        = strobe_on && (bs_sel || !s_bs_n || bs_seen_reg)
                     && (variant != host_port_pkg::VAR_RSVD);

  // A start pulse may lead the strobes, so it is remembered until used.
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      bs_seen_reg <= 1'b0;
    end else if (state_reg == host_port_pkg::ACC_IDLE && go) begin
      bs_seen_reg <= 1'b0;
    end else if (state_reg == host_port_pkg::ACC_IDLE && !s_bs_n && !bs_sel) begin
      bs_seen_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer and window memory
  // ---------------------------------------------------------------
  logic [23:0] addr_reg;
  logic        wr_reg;
  logic [3:0]  be_reg;
  logic [31:0] wdat_reg;
  logic [3:0]  lat_cnt;
  logic [3:0]  lat_reg;
  logic [31:0] acnt_reg;
  logic [31:0] mem [0:(1<<MEM_AW)-1];
  logic        hit;
  logic        complete;

  assign hit      = (addr_reg[23:MEM_AW] == '0);
  assign complete = (state_reg == host_port_pkg::ACC_BUSY) && (lat_cnt == 4'h0);

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      state_reg <= host_port_pkg::ACC_IDLE;
      addr_reg  <= 24'h0;
      wr_reg    <= 1'b0;
      be_reg    <= 4'h0;
      wdat_reg  <= 32'h0;
      lat_cnt   <= 4'h0;
      acnt_reg  <= 32'h0;
    end else begin
      case (state_reg)
        host_port_pkg::ACC_IDLE: begin
          if (go) begin
            state_reg <= host_port_pkg::ACC_BUSY;
            addr_reg  <= addr_eff;
            wr_reg    <= wr_req;
            be_reg    <= ~s_we_n;
            wdat_reg  <= s_data;
            lat_cnt   <= lat_reg;
          end
        end
        host_port_pkg::ACC_BUSY: begin
          if (lat_cnt == 4'h0) begin
            state_reg <= host_port_pkg::ACC_DONE;
            acnt_reg  <= acnt_reg + 32'h1;
          end else begin
            lat_cnt <= lat_cnt - 4'h1;
          end
        end
        host_port_pkg::ACC_DONE: begin
          if (!strobe_on) begin
            state_reg <= host_port_pkg::ACC_IDLE;
          end
        end
        default: state_reg <= host_port_pkg::ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (complete && wr_reg && hit) begin
      for (int b = 0; b < 4; b++) begin
        if (be_reg[b]) begin
          mem[addr_reg[MEM_AW-1:0]][8*b +: 8] <= wdat_reg[8*b +: 8];
        end
      end
    end
  end

  // Reads outside the window return zero rather than aliasing.
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      host_bus_data_o    <= 32'h0;
      host_bus_data_oe_o <= 1'b0;
    end else begin
      if (complete && !wr_reg) begin
        host_bus_data_o <= hit ? mem[addr_reg[MEM_AW-1:0]] : 32'h0;
      end
      host_bus_data_oe_o <= (complete && !wr_reg) ||
                            (state_reg == host_port_pkg::ACC_DONE && !wr_reg && strobe_on);
    end
  end

  // ---------------------------------------------------------------
  // Wait line
  // ---------------------------------------------------------------
  wait_line_if wl ();

  assign wl.ready_now  = rdy_sel ? (state_reg != host_port_pkg::ACC_BUSY)
                                 : (state_reg == host_port_pkg::ACC_DONE);
  assign wl.drive      = !s_cs_n || (state_reg != host_port_pkg::ACC_IDLE);
  assign wl.ready_high = (variant == host_port_pkg::VAR_A);

  wait_line_drv u_wait (
    .clk_i             (clk_i),
    .rst_i             (port_rst),
    .wl                (wl.drv),
    .wait_request_o    (wait_request_o),
    .wait_request_oe_o (wait_request_oe_o)
  );

  // ---------------------------------------------------------------
  // DMA handshake, interrupt and reset timing check
  // ---------------------------------------------------------------
  logic        xstb_on;
  logic        xstb_prev;
  logic        xfer;
  logic        dma_pend;
  logic [15:0] dma_cnt;
  logic        irq_bit;
  logic        ctrl_wr;
  logic        stat_wr;
  logic [31:0] hold_cnt;
  logic        hwr_prev;
  logic        rshort;

  assign xstb_on = var_c ? !s_xstb : s_xstb;
  assign xfer    = s_ack && xstb_on && !xstb_prev;

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      xstb_prev <= 1'b0;
      dma_pend  <= 1'b0;
      dma_cnt   <= 16'h0;
    end else begin
      xstb_prev <= xstb_on;
      if (ctrl_wr && wb_dat_i[`HP_CTRL_DMA_BIT]) begin
        dma_pend <= 1'b1;
      end else if (xfer) begin
        dma_pend <= 1'b0;
      end
      if (xfer && dma_pend) begin
        dma_cnt <= dma_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_request_n_o <= 1'b1;
      host_irq_o      <= 1'b1;
    end else begin
      dma_request_n_o <= !dma_pend;
      host_irq_o      <= var_c ? irq_bit : !irq_bit;
    end
  end

  // Flags a reset released too soon after the PLL came out of reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= 32'h0;
      hwr_prev <= 1'b0;
      rshort   <= 1'b0;
    end else begin
      hwr_prev <= s_hwr_n;
      if (!s_pll_n) begin
        hold_cnt <= 32'h0;
      end else if (!s_hwr_n && hold_cnt != HOLD_CYC) begin
        hold_cnt <= hold_cnt + 32'h1;
      end
      if (s_hwr_n && !hwr_prev && s_pll_n && hold_cnt < HOLD_CYC) begin
        rshort <= 1'b1;
      end else if (stat_wr && wb_dat_i[`HP_STAT_RSHORT_BIT]) begin
        rshort <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic wb_hit;

  assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrl_wr = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `HP_CTRL_OFS);
  assign stat_wr = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `HP_STAT_OFS);

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      irq_bit <= `HP_CTRL_RST;
      lat_reg <= `HP_LAT_RST;
    end else if (ctrl_wr) begin
      irq_bit <= wb_dat_i[`HP_CTRL_IRQ_BIT];
      lat_reg <= wb_dat_i[`HP_CTRL_LAT_MSB:`HP_CTRL_LAT_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        if (wb_adr_i == `HP_CTRL_OFS) begin
          wb_dat_o <= {24'h0, lat_reg, 2'b00, dma_pend, irq_bit};
        end else if (wb_adr_i == `HP_STAT_OFS) begin
          wb_dat_o <= {dma_cnt, 9'h0, rshort, bs_sel, rdy_sel, strap_reg[4], strap_reg[4:2]};
        end else if (wb_adr_i == `HP_ACNT_OFS) begin
          wb_dat_o <= acnt_reg;
        end else begin
          wb_dat_o <= 32'h0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rsvd_idle_a: assert property (
    (variant == host_port_pkg::VAR_RSVD && !port_rst) |=> state_reg == host_port_pkg::ACC_IDLE)
    else $error("access started in reserved variant");
  no_pulse_a: assert property (
    (state_reg == host_port_pkg::ACC_IDLE && !bs_sel && s_bs_n && !bs_seen_reg && !port_rst)
    |=> state_reg == host_port_pkg::ACC_IDLE)
    else $error("access started without bus-start pulse");
  narrow_addr_a: assert property (
    (state_reg == host_port_pkg::ACC_BUSY && var_cd) |-> addr_reg[23:22] == 2'b00)
    else $error("narrow variant used upper address bits");
  alt_write_a: assert property (
    (state_reg == host_port_pkg::ACC_IDLE && go && var_c && s_addr[`HP_ALT_WR_BIT] && !port_rst)
    |=> !wr_reg)
    else $error("variant C write taken without alternate strobe");
  dma_req_a: assert property (
    (dma_pend && !port_rst) |=> ##1 !dma_request_n_o || !$past(dma_pend))
    else $error("pending DMA not requested low");
  dma_done_a: assert property (
    (xfer && !ctrl_wr && !port_rst) |=> !dma_pend ##1 dma_request_n_o)
    else $error("DMA request not withdrawn after transfer strobe");
  irq_level_a: assert property (
    ($stable(irq_bit) && $stable(variant)) [*2] |-> host_irq_o == (var_c ? irq_bit : !irq_bit))
    else $error("interrupt level wrong for variant");
  hw_reset_a: assert property (
    !s_hwr_n |=> state_reg == host_port_pkg::ACC_IDLE && !host_bus_data_oe_o)
    else $error("port not idle under hardware reset");
  nnr_wait_a: assert property (
    (!rdy_sel && state_reg == host_port_pkg::ACC_BUSY && !port_rst)
    |=> wait_request_o == !wl.ready_high || port_rst)
    else $error("ready shown before access completed");

  read_cov_c: cover property (complete && !wr_reg ##1 host_bus_data_oe_o);
  write_cov_c: cover property (complete && wr_reg && be_reg == 4'h5);
  dma_cov_c: cover property (dma_pend ##[1:50] xfer);
  varc_cov_c: cover property (var_c && complete);
endmodule

/* File: host_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor and external DMA controller seen from the port.
// ----------------------------------------------------------------
module host_cpu_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  variant_i,
  input  wire logic        ready_mode_i,
  input  wire logic        bs_absent_i,
  input  wire logic        wait_request_i,
  input  wire logic        wait_request_oe_i,
  input  wire logic [31:0] data_i,
  input  wire logic        data_oe_i,
  input  wire logic        dma_request_n_i,
  output logic             chip_sel_n_o,
  output logic             read_strobe_n_o,
  output logic [3:0]       byte_write_strobe_n_o,
  output logic [23:0]      address_o,
  output logic [31:0]      data_o,
  output logic             bus_cycle_start_n_o,
  output logic             dma_acknowledge_o,
  output logic             dma_transfer_strobe_o
);
  logic use_pulse = 1'b0;
  logic alt_high  = 1'b0;
  logic strobe_on = 1'b0;
  logic ready_lvl;
  assign ready_lvl = (variant_i == 3'b000);
  assign dma_transfer_strobe_o = strobe_on ^ (variant_i == 3'b010);
  initial begin
    chip_sel_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    byte_write_strobe_n_o = 4'hf;
    address_o = 24'h000000;
    data_o = 32'h00000000;
    bus_cycle_start_n_o = 1'b1;
    dma_acknowledge_o = 1'b0;
  end
  task automatic access(input logic we, input logic [23:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic ok,
                        output logic oe);
    logic seen_wait;
    int   i;
    seen_wait = !ready_mode_i;
    ok = 1'b0;
    q = 32'h00000000;
    oe = 1'b0;
    @(posedge clk_i);
    chip_sel_n_o <= 1'b0;
    // In variant C the alternate write strobe rides on address bit 22.
    address_o <= (variant_i == 3'b010 && we) ? {a[23], alt_high, a[21:0]} : a;
    read_strobe_n_o <= we;
    byte_write_strobe_n_o <= we ? ~be : 4'hf;
    data_o <= we ? d : ~data_o;
    bus_cycle_start_n_o <= !(use_pulse && !bs_absent_i);
    @(posedge clk_i);
    bus_cycle_start_n_o <= 1'b1;
    // Software wait cycles are only a minimum; the ready line still decides.
    if (ready_mode_i) repeat (bs_absent_i ? 2 : 1) @(posedge clk_i);
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_i);
      if (wait_request_oe_i && wait_request_i !== ready_lvl) seen_wait = 1'b1;
      else if (wait_request_oe_i && seen_wait && wait_request_i === ready_lvl) begin
        ok = 1'b1;
        q = data_i;
        oe = data_oe_i;
      end
    end
    chip_sel_n_o <= 1'b1;
    read_strobe_n_o <= 1'b1;
    byte_write_strobe_n_o <= 4'hf;
    address_o <= ~address_o;
    data_o <= ~data_o;
    for (i = 0; i < 12 && wait_request_oe_i !== 1'b0; i++) @(posedge clk_i);
  endtask
  task automatic dma_cycle(output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 20 && dma_request_n_i !== 1'b0; i++) @(posedge clk_i);
    if (dma_request_n_i === 1'b0) begin
      dma_acknowledge_o <= 1'b1;
      @(posedge clk_i);
      strobe_on <= 1'b1;
      @(posedge clk_i);
      strobe_on <= 1'b0;
      @(posedge clk_i);
      dma_acknowledge_o <= 1'b0;
      for (i = 0; i < 10 && !ok; i++) begin
        @(posedge clk_i);
        ok = (dma_request_n_i === 1'b1);
      end
    end
  endtask
endmodule

/* File: tb_host_bus_port.sv */
`timescale 1ns/1ps
module tb_host_bus_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, byte_write_strobe_n_i;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, host_bus_data_i, host_bus_data_o, host_data;
  logic [2:0] host_variant_sel_i = 3'h0;
  logic ready_polarity_sel_i = 1'b0, bus_start_present_sel_i = 1'b1;
  logic hw_reset_n_i = 1'b0, pll_reset_n_i = 1'b0;
  logic bus_cycle_start_n_i, chip_sel_n_i, read_strobe_n_i, host_bus_data_oe_o;
  logic wait_request_o, wait_request_oe_o, dma_request_n_o, host_irq_o;
  logic dma_acknowledge_i, dma_transfer_strobe_i;
  logic [23:0] host_word_address_i;
  int n_mismatch = 0;
  int num_checks = 0;
  integer seed = 32'hc9324f3c;
  always #2.5 clk_i = ~clk_i;
  assign host_bus_data_i = host_bus_data_oe_o ? host_bus_data_o : host_data;
  host_bus_port #(.MEM_AW(8), .RESET_HOLD_CYC(20)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_variant_sel_i,
    .ready_polarity_sel_i, .bus_start_present_sel_i, .hw_reset_n_i, .pll_reset_n_i,
    .bus_cycle_start_n_i, .chip_sel_n_i, .read_strobe_n_i, .byte_write_strobe_n_i,
    .host_word_address_i, .host_bus_data_i, .host_bus_data_o, .host_bus_data_oe_o,
    .wait_request_o, .wait_request_oe_o, .dma_request_n_o, .dma_acknowledge_i,
    .dma_transfer_strobe_i, .host_irq_o);
  host_cpu_model host (.clk_i(clk_i), .variant_i(host_variant_sel_i),
    .ready_mode_i(ready_polarity_sel_i), .bs_absent_i(bus_start_present_sel_i),
    .wait_request_i(wait_request_o), .wait_request_oe_i(wait_request_oe_o),
    .data_i(host_bus_data_i), .data_oe_i(host_bus_data_oe_o), .dma_request_n_i(dma_request_n_o),
    .chip_sel_n_o(chip_sel_n_i), .read_strobe_n_o(read_strobe_n_i),
    .byte_write_strobe_n_o(byte_write_strobe_n_i), .address_o(host_word_address_i),
    .data_o(host_data), .bus_cycle_start_n_o(bus_cycle_start_n_i),
    .dma_acknowledge_o(dma_acknowledge_i), .dma_transfer_strobe_o(dma_transfer_strobe_i));
  // ----------------------------------------------------------------
  // Checking helpers and bus tasks.
  // ----------------------------------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic idle_lvl();
    return ready_polarity_sel_i ~^ (host_variant_sel_i == 3'b000);
  endfunction
  function logic irq_off();
    return host_variant_sel_i != 3'b010;
  endfunction
  function logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    for (int k = 0; k < 4; k++) if (be[k]) o[8*k +: 8] = n[8*k +: 8];
    return o;
  endfunction
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task hop(input logic we, input logic [23:0] a, input logic [31:0] d, input logic [3:0] be,
           input logic ok_exp, input logic [31:0] q_exp);
    logic [31:0] q;
    logic ok, oe;
    host.access(we, a, d, be, q, ok, oe);
    check(ok, ok_exp);
    if (ok && !we) check(q, q_exp);
    if (ok) check(oe, !we);
    check(wait_request_o, idle_lvl());
    check(wait_request_oe_o, 1'b0);
    check(host_bus_data_oe_o, 1'b0);
  endtask
  task do_reset(input logic [2:0] v, input logic rp, input logic bsp);
    @(posedge clk_i);
    rst_i <= 1'b1;
    hw_reset_n_i <= 1'b0;
    host_variant_sel_i <= v;
    ready_polarity_sel_i <= rp;
    bus_start_present_sel_i <= bsp;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    hw_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q, d, e;
    logic [23:0] a;
    logic [3:0]  be;
    logic        ok;
    int          v, k;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    pll_reset_n_i <= 1'b1;
    // Deliberately too early: the port must flag the short hold.
    repeat (6) @(posedge clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, q);
    check(q[6], 1'b1);
    wb(1'b1, 8'h04, 32'h40, q);
    wb(1'b0, 8'h04, 32'h0, q);
    check(q[6], 1'b0);
    for (v = 0; v < 4; v++) begin
      do_reset(v[2:0], 1'b0, 1'b1);
      check(wait_request_o, idle_lvl());
      check(host_irq_o, irq_off());
      check(dma_request_n_o, 1'b1);
      wb(1'b0, 8'h04, 32'h0, q);
      check(q[5:0], {3'b100, v[2:0]});
      wb(1'b1, 8'h00, 32'h1, q);
      repeat (2) @(posedge clk_i);
      check(host_irq_o, !irq_off());
      for (k = 0; k < 3; k++) begin
        a = {16'h0000, 8'($random(seed))};
        e = $random(seed);
        d = $random(seed);
        be = 4'($random(seed)) | 4'(1 << k);
        hop(1'b1, a, e, 4'hf, 1'b1, 32'h0);
        hop(1'b1, a, d, be, 1'b1, 32'h0);
        hop(1'b0, a, 32'h0, 4'h0, 1'b1, merge(e, d, be));
      end
      hop(1'b0, 24'h000100, 32'h0, 4'h0, 1'b1, 32'h0);
      wb(1'b0, 8'h08, 32'h0, q);
      check(q, 32'h0000000a);
      wb(1'b0, 8'h0c, 32'h0, q);
      check(q, 32'h0);
      wb(1'b1, 8'h00, 32'h2, q);
      host.dma_cycle(ok);
      check(ok, 1'b1);
      wb(1'b0, 8'h04, 32'h0, q);
      check(q[31:16], 16'h0001);
      check(host_irq_o, irq_off());
    end
    hop(1'b1, 24'hc00020, 32'h5a5aa5a5, 4'hf, 1'b1, 32'h0);
    hop(1'b0, 24'h000020, 32'h0, 4'h0, 1'b1, 32'h5a5aa5a5);
    do_reset(3'b010, 1'b0, 1'b1);
    host.alt_high = 1'b1;
    hop(1'b1, 24'h000010, 32'h1, 4'hf, 1'b0, 32'h0);
    host.alt_high = 1'b0;
    hop(1'b1, 24'h000010, 32'h1, 4'hf, 1'b1, 32'h0);
    hop(1'b0, 24'h400010, 32'h0, 4'h0, 1'b1, 32'h1);
    do_reset(3'b100, 1'b0, 1'b1);
    wb(1'b0, 8'h04, 32'h0, q);
    check(q[5:0], 6'b101100);
    hop(1'b0, 24'h000010, 32'h0, 4'h0, 1'b0, 32'h0);
    do_reset(3'b001, 1'b0, 1'b0);
    hop(1'b0, 24'h000010, 32'h0, 4'h0, 1'b0, 32'h0);
    host.use_pulse = 1'b1;
    hop(1'b1, 24'h000010, 32'hcafe0001, 4'hf, 1'b1, 32'h0);
    hop(1'b0, 24'h000010, 32'h0, 4'h0, 1'b1, 32'hcafe0001);
    for (v = 0; v < 2; v++) begin
      do_reset(v[2:0], 1'b1, v == 0);
      check(wait_request_o, idle_lvl());
      hop(1'b1, 24'h000030, 32'h0badf00d, 4'hf, 1'b1, 32'h0);
      hop(1'b0, 24'h000030, 32'h0, 4'h0, 1'b1, 32'h0badf00d);
    end
    wb(1'b1, 8'h00, 32'h1, q);
    hw_reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(host_irq_o, irq_off());
    wb(1'b0, 8'h00, 32'h0, q);
    check(q[0], 1'b0);
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule
